// ==== core/aiorg_pkg.sv ====
// package of register map, field layout and reset values for the analog io register bank
package aiorg_pkg;
   // ==========================================================
   // register byte offsets
   localparam logic [7:0]  IRQ_CTRL_OFS      = 8'h04;
   localparam logic [7:0]  OUT_QUEUE_OFS     = 8'h18;
   localparam logic [7:0]  OUT_QCTRL_OFS     = 8'h1c;
   localparam logic [7:0]  DISC_OUT_OFS      = 8'h24;
   // ==========================================================
   // reset values
   localparam logic [31:0] IRQ_CTRL_RST      = 32'h0000_0008;
   localparam logic [14:0] THRESH_RST        = 15'h7ffe;
   localparam logic [3:0]  DISC_OUT_RST      = 4'h0;
   localparam logic [3:0]  INPUT_MODE_RST    = 4'h0;
   // ==========================================================
   // output queue word layout
   localparam int SAMPLE_LSB     = 0;
   localparam int SAMPLE_W       = 16;
   localparam int CHAN_LSB       = 16;
   localparam int CHAN_W         = 3;
   localparam int GROUP_END_BIT  = 19;
   localparam int BURST_END_BIT  = 20;
   localparam int QWORD_W        = 21;
   // ==========================================================
   // queue control, interrupt control and discrete output fields
   localparam int THRESH_W       = 15;
   localparam int QCLEAR_BIT     = 15;
   localparam int QFLAG_BIT      = 16;
   localparam int G0_SEL_LSB     = 0;
   localparam int G0_PEND_BIT    = 3;
   localparam int G1_SEL_LSB     = 4;
   localparam int G1_PEND_BIT    = 7;
   localparam int G2_SEL_LSB     = 8;
   localparam int G2_PEND_BIT    = 11;
   localparam int SEL_W          = 3;
   localparam int DISC_W         = 4;
   // ==========================================================
   // event selector codes
   localparam logic [2:0] SEL_IDLE      = 3'h0;
   localparam logic [2:0] SEL_G0_CAL    = 3'h1;
   localparam logic [2:0] SEL_RISE      = 3'h1;
   localparam logic [2:0] SEL_FALL      = 3'h2;
   localparam logic [2:0] SEL_G2_BURST  = 3'h3;
   // ==========================================================
   // input function codes
   typedef enum logic [3:0] {
      AIORG_DIFF   = 4'h0,
      AIORG_SINGLE = 4'h1,
      AIORG_ZERO   = 4'h2,
      AIORG_VREF   = 4'h3,
      AIORG_MON0   = 4'h4,
      AIORG_MON7   = 4'hb
   } aiorg_mode_t;
endpackage : aiorg_pkg

// ==== core/aiorg_fifo.sv ====
// parameterised flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module aiorg_fifo #(
   parameter int WIDTH = 21,
   parameter int DEPTH = 16
) (
   input  wire logic             mclk,
   input  wire logic             rstN,
   input  wire logic             flush,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   // pointer wrap relies on a power-of-two depth
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_bad
      $error("depth must be a power of two");
   end
   // ==========================================================
   // storage and pointers
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wrPtr_q;
   logic [AW:0]      rdPtr_q;
   wire              push = inValid && inReady;
   wire              pop  = outValid && outReady;
   assign level    = wrPtr_q - rdPtr_q;
   assign inReady  = (level != (AW+1)'(DEPTH));
   assign outValid = (level != '0);
   assign outData  = mem[rdPtr_q[AW-1:0]];
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
      end else if (flush) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
      end else begin
         if (push) wrPtr_q <= wrPtr_q + 1'b1;
         if (pop)  rdPtr_q <= rdPtr_q + 1'b1;
      end
   end
   always_ff @(posedge mclk) begin
      if (push) mem[wrPtr_q[AW-1:0]] <= inData;
   end
endmodule : aiorg_fifo
`default_nettype wire

// ==== core/aiorg_regs.sv ====
// register bank: input mode, output sample queue, queue control, lines, irq
//
// Overview of operation
// R1: input function field; 0 differential (reset), 1 single-ended
// R2: code 2 grounds all inputs, code 3 applies reference, for self-test
// R3: codes 4 to 11 monitor output channels 0 to 7; 12-15 reserved
// R4: queue word bits 0-15 hold the sample, bit 15 most significant
// R5: queue word bits 16-18 carry the output channel number
// R6: bit 19 marks last channel of a channel group
// R7: bit 20 optionally marks last channel of a burst
// R8: bits 21-31 of queue writes are ignored
// R9: reading the queue location returns zero and leaves contents alone
// R10: queue control holds 15-bit threshold, reset 7ffe
// R11: writing one to control bit 15 empties the queue
// R12: clear bit returns to zero when clear finishes
// R13: control bit 16 high while queue level exceeds threshold
// R14: discrete register bits 0-3 drive four lines, uninverted, reset zero
// R15: group 0 selector: 0 idle, 1 calibration done, 2-7 reserved
// R16: group 0 pending bit sets when selected condition occurs
// R17: host writes zero to a pending bit to clear that request
// R18: interrupt control resets to 0x8, group 0 pending set
// R19: group 1 selector 0 selects no condition
// R20: group 1 codes 1 and 2: input threshold rise or fall
// R21: group 2 codes 1,2,3: output threshold rise, fall, burst done
// R22: bits 7 and 11 are group 1 and 2 pending, like group 0
// R23: output queue is first-in first-out in host write order
// R24: inactive bits read zero and ignore writes
`timescale 1ns/1ps
`default_nettype none
module aiorg_regs #(
   parameter int DEPTH = 16
) (
   input  wire logic        mclk,
   input  wire logic        reset_n,
   input  wire logic [7:0]  busAddr,
   input  wire logic        busWr,
   input  wire logic        busRd,
   input  wire logic [31:0] busWrData,
   output logic      [31:0] busRdData,
   output logic             busWrReady,
   input  wire logic [3:0]  inputModeIn,
   output logic             selDiff,
   output logic             selSingle,
   output logic             selZero,
   output logic             selVref,
   output logic             selMonitor,
   output logic      [2:0]  monitorChan,
   output logic             sampleValid,
   input  wire logic        sampleReady,
   output logic      [15:0] sampleData,
   output logic      [2:0]  sampleChan,
   output logic             sampleGroupEnd,
   output logic             sampleBurstEnd,
   input  wire logic        calDone,
   input  wire logic        inThreshFlag,
   output logic      [3:0]  discreteOut,
   output logic             irqPending
);
   localparam int LW = $clog2(DEPTH) + 1;
   // the threshold field is 15 bits and the level is cut to 15 bits, so deeper queues would flag wrongly
   if (DEPTH > 32767) begin : g_depth_bad
      $error("depth exceeds threshold range");
   end
   // ==========================================================
   // reset synchroniser
   logic rstMeta_q;
   logic rstN_q;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta_q <= 1'b0;
         rstN_q    <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstN_q    <= rstMeta_q;
      end
   end
   // ==========================================================
   // address decode
   wire hitIrq   = (busAddr == aiorg_pkg::IRQ_CTRL_OFS);
   wire hitQueue = (busAddr == aiorg_pkg::OUT_QUEUE_OFS);
   wire hitQctl  = (busAddr == aiorg_pkg::OUT_QCTRL_OFS);
   wire hitDisc  = (busAddr == aiorg_pkg::DISC_OUT_OFS);
   wire wrIrq    = busWr && hitIrq;
   wire wrQctl   = busWr && hitQctl;
   wire wrDisc   = busWr && hitDisc;
   // ==========================================================
   // input function decode
   logic [3:0] inputMode_q;
   always_ff @(posedge mclk or negedge rstN_q) begin
      if (!rstN_q) inputMode_q <= aiorg_pkg::INPUT_MODE_RST; // R1
      else         inputMode_q <= inputModeIn;
   end
   assign selDiff    = (inputMode_q == aiorg_pkg::AIORG_DIFF);   // R1
   assign selSingle  = (inputMode_q == aiorg_pkg::AIORG_SINGLE); // R1
   assign selZero    = (inputMode_q == aiorg_pkg::AIORG_ZERO);   // R2
   assign selVref    = (inputMode_q == aiorg_pkg::AIORG_VREF);   // R2
   // reserved codes select nothing so no path is switched by accident
   assign selMonitor = (inputMode_q >= aiorg_pkg::AIORG_MON0) &&
                       (inputMode_q <= aiorg_pkg::AIORG_MON7);   // R3
   wire [3:0] monOffset = inputMode_q - aiorg_pkg::AIORG_MON0;
   assign monitorChan = monOffset[2:0];                          // R3
   // ==========================================================
   // output sample queue
   logic [aiorg_pkg::THRESH_W-1:0] thresh_q;
   logic                           clear_q;
   logic [LW-1:0]                  level;
   logic [aiorg_pkg::QWORD_W-1:0]  qHead;
   wire  qPush = busWr && hitQueue;
   // bits above the burst flag are dropped before storage
   wire [aiorg_pkg::QWORD_W-1:0] qIn =
      busWrData[aiorg_pkg::QWORD_W-1:0];                         // R8
   aiorg_fifo #(
      .WIDTH (aiorg_pkg::QWORD_W),
      .DEPTH (DEPTH)
   ) aiorg_fifo_inst (
      .mclk     (mclk),
      .rstN     (rstN_q),
      .flush    (clear_q),                                       // R11
      .inValid  (qPush),
      .inReady  (busWrReady),
      .inData   (qIn),
      .outValid (sampleValid),                                   // R23
      .outReady (sampleReady),
      .outData  (qHead),
      .level    (level)
   );
   assign sampleData     = qHead[aiorg_pkg::SAMPLE_LSB +:
                                 aiorg_pkg::SAMPLE_W];           // R4
   assign sampleChan     = qHead[aiorg_pkg::CHAN_LSB +:
                                 aiorg_pkg::CHAN_W];             // R5
   assign sampleGroupEnd = qHead[aiorg_pkg::GROUP_END_BIT];      // R6
   assign sampleBurstEnd = qHead[aiorg_pkg::BURST_END_BIT];      // R7
   // ==========================================================
   // queue control
   wire qFlag = (15'(level) > thresh_q);                         // R13
   always_ff @(posedge mclk or negedge rstN_q) begin
      if (!rstN_q) begin
         thresh_q <= aiorg_pkg::THRESH_RST;                      // R10
         clear_q  <= 1'b0;
      end else begin
         if (wrQctl) thresh_q <= busWrData[aiorg_pkg::THRESH_W-1:0];
         // the flush takes one cycle, then the bit drops by itself
         clear_q <= wrQctl && busWrData[aiorg_pkg::QCLEAR_BIT];  // R11 R12
      end
   end
   // ==========================================================
   // discrete output lines
   logic [aiorg_pkg::DISC_W-1:0] disc_q;
   always_ff @(posedge mclk or negedge rstN_q) begin
      if (!rstN_q)     disc_q <= aiorg_pkg::DISC_OUT_RST;        // R14
      else if (wrDisc) disc_q <= busWrData[aiorg_pkg::DISC_W-1:0];
   end
   assign discreteOut = disc_q;                                  // R14
   // ==========================================================
   // interrupt control
   logic [2:0] g0Sel_q;
   logic [2:0] g1Sel_q;
   logic [2:0] g2Sel_q;
   logic       g0Pend_q;
   logic       g1Pend_q;
   logic       g2Pend_q;
   logic       inFlagPrev_q;
   logic       qFlagPrev_q;
   logic       calPrev_q;
   wire burstDone = sampleValid && sampleReady && sampleBurstEnd;
   wire g0Evt = (g0Sel_q == aiorg_pkg::SEL_G0_CAL) &&
                calDone && !calPrev_q;                           // R15 R16
   wire g1Evt = ((g1Sel_q == aiorg_pkg::SEL_RISE) &&
                 inThreshFlag && !inFlagPrev_q) ||
                ((g1Sel_q == aiorg_pkg::SEL_FALL) &&
                 !inThreshFlag && inFlagPrev_q);                 // R19 R20
   wire g2Evt = ((g2Sel_q == aiorg_pkg::SEL_RISE) &&
                 qFlag && !qFlagPrev_q) ||
                ((g2Sel_q == aiorg_pkg::SEL_FALL) &&
                 !qFlag && qFlagPrev_q) ||
                ((g2Sel_q == aiorg_pkg::SEL_G2_BURST) && burstDone); // R21
   // a write of zero clears, but a same-cycle event wins
   wire g0PendD = g0Evt || (wrIrq ? busWrData[aiorg_pkg::G0_PEND_BIT]
                                  : g0Pend_q);                   // R16 R17
   wire g1PendD = g1Evt || (wrIrq ? busWrData[aiorg_pkg::G1_PEND_BIT]
                                  : g1Pend_q);                   // R22 R17
   wire g2PendD = g2Evt || (wrIrq ? busWrData[aiorg_pkg::G2_PEND_BIT]
                                  : g2Pend_q);                   // R22 R17
   always_ff @(posedge mclk or negedge rstN_q) begin
      if (!rstN_q) begin
         g0Sel_q      <= aiorg_pkg::IRQ_CTRL_RST[2:0];           // R18
         g1Sel_q      <= aiorg_pkg::IRQ_CTRL_RST[6:4];
         g2Sel_q      <= aiorg_pkg::IRQ_CTRL_RST[10:8];
         g0Pend_q     <= aiorg_pkg::IRQ_CTRL_RST[3];             // R18
         g1Pend_q     <= aiorg_pkg::IRQ_CTRL_RST[7];
         g2Pend_q     <= aiorg_pkg::IRQ_CTRL_RST[11];
         inFlagPrev_q <= 1'b0;
         qFlagPrev_q  <= 1'b0;
         calPrev_q    <= 1'b0;
      end else begin
         if (wrIrq) begin
            g0Sel_q <= busWrData[aiorg_pkg::G0_SEL_LSB +: aiorg_pkg::SEL_W];
            g1Sel_q <= busWrData[aiorg_pkg::G1_SEL_LSB +: aiorg_pkg::SEL_W];
            g2Sel_q <= busWrData[aiorg_pkg::G2_SEL_LSB +: aiorg_pkg::SEL_W];
         end
         g0Pend_q     <= g0PendD;
         g1Pend_q     <= g1PendD;
         g2Pend_q     <= g2PendD;
         inFlagPrev_q <= inThreshFlag;
         qFlagPrev_q  <= qFlag;
         calPrev_q    <= calDone;
      end
   end
   assign irqPending = g0Pend_q || g1Pend_q || g2Pend_q;
   // ==========================================================
   // read mux; the queue location and unmapped offsets read zero
   wire [31:0] rdIrq  = {20'h0, g2Pend_q, g2Sel_q, g1Pend_q, g1Sel_q,
                         g0Pend_q, g0Sel_q};                     // R24
   wire [31:0] rdQctl = {15'h0, qFlag, clear_q, thresh_q};       // R13 R24
   wire [31:0] rdDisc = {28'h0, disc_q};                         // R24
   wire [31:0] rdMux  = hitIrq  ? rdIrq  :
                        hitQctl ? rdQctl :
                        hitDisc ? rdDisc : 32'h0;                // R9
   always_ff @(posedge mclk or negedge rstN_q) begin
      if (!rstN_q)    busRdData <= 32'h0;
      else if (busRd) busRdData <= rdMux;
   end
   // ==========================================================
   // checks
   property p_clear_self;
      @(posedge mclk) disable iff (!rstN_q)
      (clear_q && !wrQctl) |=> !clear_q;
   endproperty
   a_clear_self: assert property (p_clear_self) // R12
      else $error("clear bit did not drop");
   property p_clear_empties;
      @(posedge mclk) disable iff (!rstN_q)
      clear_q |=> (level == '0);
   endproperty
   a_clear_empties: assert property (p_clear_empties) // R11
      else $error("queue not empty after clear");
   property p_flag;
      @(posedge mclk) disable iff (!rstN_q)
      rdQctl[aiorg_pkg::QFLAG_BIT] ==
         ((level != '0) && (15'(level - 1'b1) >= thresh_q));
   endproperty
   a_flag: assert property (p_flag) // R13
      else $error("threshold flag wrong");
   property p_queue_read_zero;
      @(posedge mclk) disable iff (!rstN_q)
      (busRd && hitQueue) |=> (busRdData == 32'h0);
   endproperty
   a_queue_read_zero: assert property (p_queue_read_zero) // R9
      else $error("queue read not zero");
   property p_queue_read_keeps;
      @(posedge mclk) disable iff (!rstN_q)
      (busRd && hitQueue && !busWr && !sampleReady && !clear_q)
         |=> (level == $past(level));
   endproperty
   a_queue_read_keeps: assert property (p_queue_read_keeps) // R9
      else $error("queue read disturbed level");
   property p_disc;
      @(posedge mclk) disable iff (!rstN_q)
      wrDisc |=> (discreteOut == $past(busWrData[3:0]));
   endproperty
   a_disc: assert property (p_disc) // R14
      else $error("discrete lines not updated");
   property p_g1_rise;
      @(posedge mclk) disable iff (!rstN_q)
      (g1Sel_q == aiorg_pkg::SEL_RISE && $rose(inThreshFlag))
         |=> g1Pend_q;
   endproperty
   a_g1_rise: assert property (p_g1_rise) // R20
      else $error("group 1 rise missed");
   property p_g2_burst;
      @(posedge mclk) disable iff (!rstN_q)
      (g2Sel_q == aiorg_pkg::SEL_G2_BURST && burstDone) |=> g2Pend_q;
   endproperty
   a_g2_burst: assert property (p_g2_burst) // R21
      else $error("burst completion missed");
   property p_ack;
      @(posedge mclk) disable iff (!rstN_q)
      (wrIrq && !busWrData[aiorg_pkg::G0_PEND_BIT] && !g0Evt)
         |=> !g0Pend_q;
   endproperty
   a_ack: assert property (p_ack) // R17
      else $error("group 0 request not cleared");
   property p_idle_quiet;
      @(posedge mclk) disable iff (!rstN_q)
      (g1Sel_q == aiorg_pkg::SEL_IDLE && !wrIrq && !g1Pend_q)
         |=> !g1Pend_q;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) // R19
      else $error("idle group 1 raised a request");
   sequence s_clear_write;
      wrQctl && busWrData[aiorg_pkg::QCLEAR_BIT];
   endsequence
   sequence s_clear_done;
      clear_q ##1 (level == '0 && !sampleValid);
   endsequence
   property p_clear_steps;
      @(posedge mclk) disable iff (!rstN_q)
      s_clear_write |=> s_clear_done;
   endproperty
   a_clear_steps: assert property (p_clear_steps) // R11
      else $error("clear steps incomplete");
   property p_reset_values;
      @(posedge mclk) disable iff (!rstN_q)
      $rose(rstN_q) |-> (g0Pend_q && !g1Pend_q && !g2Pend_q &&
         disc_q == aiorg_pkg::DISC_OUT_RST &&
         inputMode_q == aiorg_pkg::INPUT_MODE_RST &&
         thresh_q == aiorg_pkg::THRESH_RST);
   endproperty
   a_reset_values: assert property (p_reset_values) // R18
      else $error("register not at reset value");
   property p_disc_hold;
      @(posedge mclk) disable iff (!rstN_q)
      !wrDisc |=> $stable(discreteOut);
   endproperty
   a_disc_hold: assert property (p_disc_hold) // R14
      else $error("discrete lines moved without a write");
   property p_g0_cal;
      @(posedge mclk) disable iff (!rstN_q)
      (g0Sel_q == aiorg_pkg::SEL_G0_CAL && $rose(calDone)) |=> g0Pend_q;
   endproperty
   a_g0_cal: assert property (p_g0_cal) // R16
      else $error("calibration request missed");
   property p_g0_reserved;
      @(posedge mclk) disable iff (!rstN_q)
      (g0Sel_q != aiorg_pkg::SEL_G0_CAL && !wrIrq && !g0Pend_q)
         |=> !g0Pend_q;
   endproperty
   a_g0_reserved: assert property (p_g0_reserved) // R15
      else $error("idle group 0 raised a request");
   property p_g1_fall;
      @(posedge mclk) disable iff (!rstN_q)
      (g1Sel_q == aiorg_pkg::SEL_FALL && $fell(inThreshFlag))
         |=> g1Pend_q;
   endproperty
   a_g1_fall: assert property (p_g1_fall) // R20
      else $error("group 1 fall missed");
   property p_g2_edge;
      @(posedge mclk) disable iff (!rstN_q)
      ((g2Sel_q == aiorg_pkg::SEL_RISE && $rose(qFlag)) ||
       (g2Sel_q == aiorg_pkg::SEL_FALL && $fell(qFlag))) |=> g2Pend_q;
   endproperty
   a_g2_edge: assert property (p_g2_edge) // R21
      else $error("output threshold edge missed");
   property p_ack_g2;
      @(posedge mclk) disable iff (!rstN_q)
      (wrIrq && !busWrData[aiorg_pkg::G2_PEND_BIT] && !g2Evt)
         |=> !g2Pend_q;
   endproperty
   a_ack_g2: assert property (p_ack_g2) // R22
      else $error("group 2 request not cleared");
endmodule : aiorg_regs
`default_nettype wire

// ==== sim/aiorg_host.sv ====
// host bus master model for the register bank, driving at the falling edge
`timescale 1ns/1ps
`default_nettype none
module aiorg_host (
   input  wire logic        mclk,
   output logic      [7:0]  busAddr,
   output logic             busWr,
   output logic             busRd,
   output logic      [31:0] busWrData,
   input  wire logic [31:0] busRdData
);
   // ==========================================================
   // idle bus
   initial begin
      busAddr   = 8'h00;
      busWr     = 1'b0;
      busRd     = 1'b0;
      busWrData = 32'h0000_0000;
   end
   // ==========================================================
   // one-cycle strobes; data inverted afterwards so stale data cannot pass
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge mclk);
      busAddr   = a;
      busWr     = 1'b1;
      busWrData = d;
      @(negedge mclk);
      busWr     = 1'b0;
      busWrData = ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(negedge mclk);
      busAddr = a;
      busRd   = 1'b1;
      @(negedge mclk);
      busRd   = 1'b0;
      d       = busRdData;
   endtask : rd
endmodule : aiorg_host
`default_nettype wire

// ==== sim/aiorg_regs_tb.sv ====
// self-checking testbench for the analog io register bank
`timescale 1ns/1ps
`default_nettype none
module aiorg_regs_tb;
   logic        mclk;
   logic        resetN;
   logic [7:0]  busAddr;
   logic        busWr;
   logic        busRd;
   logic [31:0] busWrData;
   logic [31:0] busRdData;
   logic        busWrReady;
   logic [3:0]  inputModeIn;
   logic        selDiff, selSingle, selZero, selVref, selMonitor;
   logic [2:0]  monitorChan;
   logic        sampleValid;
   logic        sampleReady;
   logic [15:0] sampleData;
   logic [2:0]  sampleChan;
   logic        sampleGroupEnd, sampleBurstEnd;
   logic        calDone, inThreshFlag;
   logic [3:0]  discreteOut;
   logic        irqPending;
   int          failCount = 0;
   int          checksDone = 0;
   int          seed = 70855;
   int          i;
   logic [20:0] q[$];
   logic [31:0] w;
   aiorg_regs #(.DEPTH(16)) aiorg_regs_inst (
      .mclk(mclk), .reset_n(resetN), .busAddr(busAddr), .busWr(busWr),
      .busRd(busRd), .busWrData(busWrData), .busRdData(busRdData),
      .busWrReady(busWrReady), .inputModeIn(inputModeIn),
      .selDiff(selDiff), .selSingle(selSingle), .selZero(selZero),
      .selVref(selVref), .selMonitor(selMonitor),
      .monitorChan(monitorChan), .sampleValid(sampleValid),
      .sampleReady(sampleReady), .sampleData(sampleData),
      .sampleChan(sampleChan), .sampleGroupEnd(sampleGroupEnd),
      .sampleBurstEnd(sampleBurstEnd), .calDone(calDone),
      .inThreshFlag(inThreshFlag), .discreteOut(discreteOut),
      .irqPending(irqPending));
   aiorg_host aiorg_host_inst (
      .mclk(mclk), .busAddr(busAddr), .busWr(busWr), .busRd(busRd),
      .busWrData(busWrData), .busRdData(busRdData));
   // ==========================================================
   // clock and helpers
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask : tick
   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      checksDone++;
      if (g !== e) begin
         failCount++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      aiorg_host_inst.wr(a, d);
   endtask : wr
   task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      aiorg_host_inst.rd(a, d);
      chk($sformatf("reg %h", a), e, d);
   endtask : rdChk
   task automatic push(input logic [31:0] d);
      wr(8'h18, d);
      q.push_back(d[20:0]);
   endtask : push
   task automatic reportAndStop;
      if (failCount == 0 && checksDone > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : reportAndStop
   // ==========================================================
   // hang guard, far beyond the few hundred cycles the run needs
   initial begin
      #200000;
      failCount++;
      reportAndStop();
   end
   // ==========================================================
   // main sequence
   initial begin
      resetN       = 1'b0;
      sampleReady  = 1'b0;
      inputModeIn  = 4'h0;
      calDone      = 1'b0;
      inThreshFlag = 1'b0;
      tick(3);
      resetN = 1'b1;
      tick(4);
      chk("irq", 32'h1, {31'h0, irqPending});
      chk("lines", 32'h0, {28'h0, discreteOut});
      rdChk(8'h04, 32'h0000_0008);
      rdChk(8'h1c, 32'h0000_7ffe);
      rdChk(8'h24, 32'h0);
      rdChk(8'h18, 32'h0);
      rdChk(8'h08, 32'h0);
      for (i = 0; i < 16; i++) begin
         inputModeIn = 4'(i);
         tick(2);
         chk("mode", {27'h0, i == 0, i == 1, i == 2, i == 3,
             i > 3 && i < 12}, {27'h0, selDiff, selSingle, selZero,
             selVref, selMonitor});
         if (i > 3 && i < 12) begin
            chk("chan", 32'(i - 4), {29'h0, monitorChan});
         end
      end
      repeat (4) begin
         w = $random(seed);
         wr(8'h24, w);
         chk("lines", {28'h0, w[3:0]}, {28'h0, discreteOut});
         rdChk(8'h24, {28'h0, w[3:0]});
      end
      // fill to refusal with the drain stalled, threshold 3
      wr(8'h1c, 32'hfffe_0003);
      rdChk(8'h1c, 32'h0000_0003);
      for (i = 1; i <= 16; i++) begin
         push($random(seed));
         rdChk(8'h1c, {15'h0, i > 3, 16'h0003});
      end
      chk("ready", 32'h0, {31'h0, busWrReady});
      wr(8'h18, $random(seed));
      for (i = 0; i < 400 && q.size() > 0; i++) begin
         chk("valid", 32'h1, {31'h0, sampleValid});
         chk("word", {11'h0, q[0]}, {11'h0, sampleBurstEnd, sampleGroupEnd,
             sampleChan, sampleData});
         sampleReady = 1'($random(seed));
         if (sampleReady) begin
            void'(q.pop_front());
         end
         tick(1);
      end
      sampleReady = 1'b0;
      chk("empty", 32'h0, {31'h0, sampleValid});
      rdChk(8'h1c, 32'h0000_0003);
      // interrupt groups; selectors at zero ignore events
      wr(8'h04, 32'h0);
      chk("irq", 32'h0, {31'h0, irqPending});
      calDone      = 1'b1;
      inThreshFlag = 1'b1;
      tick(3);
      rdChk(8'h04, 32'h0);
      calDone      = 1'b0;
      inThreshFlag = 1'b0;
      wr(8'h04, 32'h1);
      calDone = 1'b1;
      tick(3);
      rdChk(8'h04, 32'h9);
      chk("irq", 32'h1, {31'h0, irqPending});
      wr(8'h04, 32'h1);
      rdChk(8'h04, 32'h1);
      wr(8'h04, 32'h10);
      inThreshFlag = 1'b1;
      tick(3);
      rdChk(8'h04, 32'h90);
      wr(8'h04, 32'h20);
      inThreshFlag = 1'b0;
      tick(3);
      rdChk(8'h04, 32'ha0);
      wr(8'h04, 32'h100);
      repeat (4) push($random(seed));
      rdChk(8'h04, 32'h900);
      wr(8'h04, 32'h200);
      wr(8'h1c, 32'h0000_8003);
      tick(1);
      chk("cleared", 32'h0, {31'h0, sampleValid});
      rdChk(8'h1c, 32'h0000_0003);
      rdChk(8'h04, 32'ha00);
      wr(8'h04, 32'h300);
      wr(8'h18, 32'h0010_0000);
      sampleReady = 1'b1;
      tick(1);
      sampleReady = 1'b0;
      tick(2);
      rdChk(8'h04, 32'hb00);
      wr(8'h04, 32'hffff_f000);
      rdChk(8'h04, 32'h0);
      reportAndStop();
   end
endmodule : aiorg_regs_tb
`default_nettype wire
